// [design/latch_max_group.sv]
// Latching-maximum bit group that keeps the largest state value seen since the last reload or clear.
`timescale 1ns/10ps
`default_nettype none
module latch_max_group #(
    parameter int WIDTH = 3
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clr,
    input wire logic reload,
    input wire logic [WIDTH-1:0] live,
    output logic [WIDTH-1:0] value_q
);
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            value_q <= '0;
        end
        else if (clr)
        begin
            value_q <= '0;
        end
        else if (reload)
        begin
            value_q <= live;
        end
        else if (live > value_q)
        begin
            value_q <= live;
        end
    end
endmodule : latch_max_group
`default_nettype wire

// [design/phy_ctrl_pkg.sv]
// Constants shared by the management control register design.
package phy_ctrl_pkg;
    localparam logic [4:0] CTRL_ADDR = 5'h00;
    localparam logic [4:0] DETAIL_STAT_ADDR = 5'h11;
    localparam int BIT_SW_RESET = 15;
    localparam int BIT_LOOPBACK = 14;
    localparam int BIT_RATE = 13;
    localparam int BIT_AN_EN = 12;
    localparam int BIT_LOW_POWER = 11;
    localparam int BIT_ISOLATE = 10;
    localparam int BIT_AN_RESTART = 9;
    localparam int BIT_DUPLEX = 8;
    localparam int BIT_COL_TEST = 7;
    localparam int STAT_BIT_RATE = 15;
    localparam int STAT_BIT_DUPLEX = 14;
    localparam int STAT_MAX_LSB = 11;
    localparam int STAT_BIT_LINK_LL = 0;
    localparam int MAX_GROUP_WIDTH = 3;
    localparam logic RST_LOOPBACK = 1'b0;
    localparam logic RST_RATE = 1'b1;
    localparam logic RST_AN_EN = 1'b1;
    localparam logic RST_LOW_POWER = 1'b0;
    localparam logic RST_DUPLEX = 1'b0;
    localparam logic RST_COL_TEST = 1'b0;
    localparam logic RST_LATCH_LOW = 1'b1;
    localparam logic [4:0] ISOLATE_ADDR = 5'h00;
    localparam int MCLK_PERIOD_NS = 50;
    localparam int SW_RESET_NS = 1000;
    localparam logic [15:0] SW_RESET_CYCLES =
        16'((SW_RESET_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
endpackage : phy_ctrl_pkg

// [design/phy_mgmt_control_register.sv]
// Control register, latching status bits and mode steering of the PHY.
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_control_register #(
    parameter int MAX_WIDTH = phy_ctrl_pkg::MAX_GROUP_WIDTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [4:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    output logic regRdValid,
    output logic regBusy,
    input wire logic configSourcePin,
    input wire logic rateSelectPin,
    input wire logic [4:0] phyAddrPin,
    input wire logic negRate100,
    input wire logic negFullDuplex,
    input wire logic anRestartBegun,
    input wire logic linkOkLive,
    input wire logic [MAX_WIDTH-1:0] anStateLive,
    input wire logic macTxEn,
    input wire logic [3:0] macTxData,
    input wire logic lineRxDv,
    input wire logic [3:0] lineRxData,
    output logic macRxDv,
    output logic [3:0] macRxData,
    output logic macOutOe_n,
    output logic lineTxEn,
    output logic [3:0] lineTxData,
    output logic lineRxEnable,
    output logic collisionDetectEn,
    output logic rate100,
    output logic fullDuplex,
    output logic autoNegEnable,
    output logic anRestartReq,
    output logic lowPower,
    output logic machineReset
);
    import phy_ctrl_pkg::*;

    logic loopback_q, rateBit_q, anEn_q, lowPower_q, isolate_q;
    logic anRestart_q, duplex_q, colTest_q, latchLow_q;
    logic swReset_q, strapDone_q;
    logic [15:0] resetCnt_q;
    logic [1:0] strapCnt_q;
    logic [1:0] cfgSync_q, rateSync_q;
    logic [4:0] addrMeta_q, addrSync_q;
    logic [MAX_WIDTH-1:0] maxValue;
    logic [15:0] ctrlView, statView;
    logic wrAccept, rdAccept, ctrlWrite, statRead, lowPowerEnter, loopIn;

    // Pins cross two flip-flops; only the second stage is read.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cfgSync_q <= 2'h0;
            rateSync_q <= 2'h0;
            addrMeta_q <= 5'h00;
            addrSync_q <= 5'h00;
        end
        else
        begin
            cfgSync_q <= {cfgSync_q[0], configSourcePin};
            rateSync_q <= {rateSync_q[0], rateSelectPin};
            addrMeta_q <= phyAddrPin;
            addrSync_q <= addrMeta_q;
        end
    end

    // The address strap is caught once the synchroniser has settled after release.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            strapCnt_q <= 2'h0;
            strapDone_q <= 1'b0;
        end
        else if (!strapDone_q)
        begin
            strapCnt_q <= strapCnt_q + 2'h1;
            strapDone_q <= (strapCnt_q == STRAP_SETTLE);
        end
    end

    assign regBusy = swReset_q | ~strapDone_q;
    assign wrAccept = regWrEn & ~regBusy;
    assign rdAccept = regRdEn & ~regBusy;
    assign ctrlWrite = wrAccept && (regAddr == CTRL_ADDR);
    assign statRead = rdAccept && (regAddr == DETAIL_STAT_ADDR);
    assign lowPowerEnter = ctrlWrite & regWrData[BIT_LOW_POWER] & ~lowPower_q;

    // Software reset runs a fixed time; bit 15 stays one until it ends.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            swReset_q <= 1'b0;
            resetCnt_q <= 16'h0000;
        end
        else if (swReset_q)
        begin
            resetCnt_q <= resetCnt_q - 16'h0001;
            swReset_q <= (resetCnt_q != 16'h0001);
        end
        else if (ctrlWrite && regWrData[BIT_SW_RESET])
        begin
            swReset_q <= 1'b1;
            resetCnt_q <= SW_RESET_CYCLES;
        end
    end

    assign machineReset = swReset_q;

    // Writable control fields; software reset and strap capture restore defaults.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            loopback_q <= RST_LOOPBACK;
            rateBit_q <= RST_RATE;
            anEn_q <= RST_AN_EN;
            lowPower_q <= RST_LOW_POWER;
            isolate_q <= 1'b0;
            duplex_q <= RST_DUPLEX;
            colTest_q <= RST_COL_TEST;
        end
        else if (swReset_q || (strapCnt_q == STRAP_SETTLE && !strapDone_q))
        begin
            loopback_q <= RST_LOOPBACK;
            rateBit_q <= RST_RATE;
            anEn_q <= RST_AN_EN;
            lowPower_q <= RST_LOW_POWER;
            isolate_q <= (addrSync_q == ISOLATE_ADDR);
            duplex_q <= RST_DUPLEX;
            colTest_q <= RST_COL_TEST;
        end
        else if (ctrlWrite && !regWrData[BIT_SW_RESET])
        begin
            loopback_q <= regWrData[BIT_LOOPBACK];
            rateBit_q <= regWrData[BIT_RATE];
            anEn_q <= regWrData[BIT_AN_EN];
            lowPower_q <= regWrData[BIT_LOW_POWER];
            isolate_q <= regWrData[BIT_ISOLATE];
            duplex_q <= regWrData[BIT_DUPLEX];
            colTest_q <= regWrData[BIT_COL_TEST];
        end
    end

    // A new restart request wins over the acknowledge arriving in the same cycle.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            anRestart_q <= 1'b0;
        end
        else if (swReset_q)
        begin
            anRestart_q <= 1'b0;
        end
        else if (ctrlWrite && regWrData[BIT_AN_RESTART] && regWrData[BIT_AN_EN])
        begin
            anRestart_q <= 1'b1;
        end
        else if (anRestartBegun || !anEn_q || (ctrlWrite && !regWrData[BIT_AN_EN]))
        begin
            anRestart_q <= 1'b0;
        end
    end

    // Latch-low link bit: an event in the reload cycle is still caught via the live value.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            latchLow_q <= RST_LATCH_LOW;
        end
        else if (swReset_q || lowPowerEnter)
        begin
            latchLow_q <= RST_LATCH_LOW;
        end
        else if (statRead)
        begin
            latchLow_q <= linkOkLive;
        end
        else
        begin
            latchLow_q <= latchLow_q & linkOkLive;
        end
    end

    latch_max_group #(
        .WIDTH(MAX_WIDTH)
    ) anProgress (
        .mclk(mclk),
        .rst(rst),
        .clr(swReset_q | lowPowerEnter),
        .reload(statRead),
        .live(anStateLive),
        .value_q(maxValue)
    );

    // Effective rate and duplex depend on the configuration source.
    always_comb
    begin
        if (!cfgSync_q[1])
        begin
            rate100 = rateSync_q[1];
            fullDuplex = duplex_q;
        end
        else if (anEn_q)
        begin
            rate100 = negRate100;
            fullDuplex = negFullDuplex;
        end
        else
        begin
            rate100 = rateBit_q;
            fullDuplex = duplex_q;
        end
    end

    assign autoNegEnable = anEn_q;
    assign anRestartReq = anRestart_q;
    assign lowPower = lowPower_q;

    always_comb
    begin
        ctrlView = 16'h0000;
        ctrlView[BIT_SW_RESET] = swReset_q;
        ctrlView[BIT_LOOPBACK] = loopback_q;
        ctrlView[BIT_RATE] = rateBit_q;
        ctrlView[BIT_AN_EN] = anEn_q;
        ctrlView[BIT_LOW_POWER] = lowPower_q;
        ctrlView[BIT_ISOLATE] = isolate_q;
        ctrlView[BIT_AN_RESTART] = anRestart_q;
        ctrlView[BIT_DUPLEX] = duplex_q;
        ctrlView[BIT_COL_TEST] = colTest_q;
        statView = 16'h0000;
        statView[STAT_BIT_RATE] = rate100;
        statView[STAT_BIT_DUPLEX] = fullDuplex;
        statView[STAT_MAX_LSB +: MAX_WIDTH] = maxValue;
        statView[STAT_BIT_LINK_LL] = latchLow_q;
    end

    // Read data is registered; unmapped addresses return zero.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            regRdData <= 16'h0000;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= rdAccept;
            if (rdAccept)
            begin
                regRdData <= (regAddr == CTRL_ADDR) ? ctrlView :
                             (regAddr == DETAIL_STAT_ADDR) ? statView : 16'h0000;
            end
        end
    end

    // Line transmit is muted in loopback, isolate and low power; line receive only in loopback and low power.
    assign lineTxEn = macTxEn & ~loopback_q & ~isolate_q & ~lowPower_q;
    assign lineTxData = lineTxEn ? macTxData : 4'h0;
    assign lineRxEnable = ~loopback_q & ~lowPower_q;
    assign collisionDetectEn = (~loopback_q | colTest_q) & ~lowPower_q;
    assign loopIn = macTxEn & ~isolate_q;
    assign macOutOe_n = isolate_q;

    // One register stage gives a single-cycle loop, far under 512 bit times.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            macRxDv <= 1'b0;
            macRxData <= 4'h0;
        end
        else if (lowPower_q)
        begin
            macRxDv <= 1'b0;
            macRxData <= 4'h0;
        end
        else if (loopback_q)
        begin
            macRxDv <= loopIn;
            macRxData <= loopIn ? macTxData : 4'h0;
        end
        else
        begin
            macRxDv <= lineRxDv;
            macRxData <= lineRxData;
        end
    end
endmodule : phy_mgmt_control_register
`default_nettype wire

// [tb/phy_mgmt_control_register_asserts.sv]
// Port assertions for the management control register.
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_control_register_asserts
    import phy_ctrl_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [4:0] regAddr,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic regBusy,
    input wire logic macTxEn,
    input wire logic macRxDv,
    input wire logic macOutOe_n,
    input wire logic lineTxEn,
    input wire logic lineRxEnable,
    input wire logic autoNegEnable,
    input wire logic anRestartReq,
    input wire logic lowPower,
    input wire logic machineReset
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    wire ctrlWr = regWrEn && !regBusy && regAddr == CTRL_ADDR;
    sequence s_resetRun;
        (regBusy && machineReset) [*8];
    endsequence
    property p_rsvd;
        regRdEn && !regBusy && regAddr == CTRL_ADDR |=> regRdData[6:0] == 7'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_swReset;
        ctrlWr && regWrData[BIT_SW_RESET] |=> s_resetRun ##[1:30] !regBusy;
    endproperty
    a_swReset: assert property (p_swReset) else $error("soft reset run");
    property p_resetBusy;
        machineReset |-> regBusy;
    endproperty
    a_resetBusy: assert property (p_resetBusy) else $error("port open in reset");
    property p_anEn;
        ctrlWr && !regWrData[BIT_SW_RESET] |=> autoNegEnable == $past(regWrData[BIT_AN_EN]);
    endproperty
    a_anEn: assert property (p_anEn) else $error("negotiation enable");
    property p_restart;
        ctrlWr && regWrData[BIT_AN_RESTART] && !regWrData[BIT_AN_EN] |=> !anRestartReq;
    endproperty
    a_restart: assert property (p_restart) else $error("restart taken");
    property p_loopTx;
        !lineRxEnable && !lowPower |-> !lineTxEn;
    endproperty
    a_loopTx: assert property (p_loopTx) else $error("line driven in loop");
    property p_loopRx;
        !lineRxEnable && !lowPower && !macOutOe_n && macTxEn |=> macRxDv;
    endproperty
    a_loopRx: assert property (p_loopRx) else $error("loop latency");
    property p_iso;
        macOutOe_n |-> !lineTxEn;
    endproperty
    a_iso: assert property (p_iso) else $error("isolate leak");
endmodule : phy_mgmt_control_register_asserts

bind phy_mgmt_control_register phy_mgmt_control_register_asserts
    u_phy_mgmt_control_register_asserts (
    .mclk, .rst, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData, .regBusy, .macTxEn,
    .macRxDv, .macOutOe_n, .lineTxEn, .lineRxEnable, .autoNegEnable, .anRestartReq, .lowPower,
    .machineReset
);
`default_nettype wire

// [tb/station_manager_model.sv]
// Station manager model driving register reads and writes.
`timescale 1ns/10ps
`default_nettype none
module station_manager_model (
    input wire logic mclk,
    input wire logic regBusy,
    output logic [4:0] regAddr,
    output logic regWrEn,
    output logic regRdEn,
    output logic [15:0] regWrData
);
    initial
    begin
        {regAddr, regWrEn, regRdEn, regWrData} = 23'h0;
    end
    // A raw access skips the idle wait and keeps reserved bits, to provoke refusals.
    task access(input logic wr, input logic [4:0] addr, input logic [15:0] data, input logic raw);
        @(negedge mclk);
        while (!raw && regBusy)
            @(negedge mclk);
        {regAddr, regWrEn, regRdEn} = {addr, wr, !wr};
        regWrData = raw ? data : {data[15:7], 7'h00};
        @(negedge mclk);
        // A released bus shows inverted values so a stale copy cannot pass.
        {regAddr, regWrEn, regRdEn, regWrData} = {~addr, 2'b00, ~regWrData};
    endtask : access
endmodule : station_manager_model
`default_nettype wire

// [tb/tb_phy_mgmt_control_register.sv]
// Self-checking bench for the management control register.
`timescale 1ns/10ps
`default_nettype none
module tb_phy_mgmt_control_register;
    import phy_ctrl_pkg::*;
    logic mclk, rst, configSourcePin, rateSelectPin, negRate100, negFullDuplex, anRestartBegun;
    logic linkOkLive, macTxEn, lineRxDv, regWrEn, regRdEn, regRdValid, regBusy, macRxDv;
    logic macOutOe_n, lineTxEn, lineRxEnable, collisionDetectEn, rate100, fullDuplex;
    logic autoNegEnable, anRestartReq, lowPower, machineReset;
    logic [4:0] regAddr, phyAddrPin;
    logic [MAX_GROUP_WIDTH-1:0] anStateLive;
    logic [3:0] macTxData, lineRxData, macRxData, lineTxData;
    logic [15:0] regWrData, regRdData;
    logic [31:0] expQ[$];
    logic [31:0] note;
    int error_cnt, cmp_count, cycles;
    phy_mgmt_control_register u_phy_mgmt_control_register (
        .mclk, .rst, .regAddr, .regWrEn, .regRdEn, .regWrData, .regRdData, .regRdValid,
        .regBusy, .configSourcePin, .rateSelectPin, .phyAddrPin, .negRate100, .negFullDuplex,
        .anRestartBegun, .linkOkLive, .anStateLive, .macTxEn, .macTxData, .lineRxDv,
        .lineRxData, .macRxDv, .macRxData, .macOutOe_n, .lineTxEn, .lineTxData,
        .lineRxEnable, .collisionDetectEn, .rate100, .fullDuplex, .autoNegEnable,
        .anRestartReq, .lowPower, .machineReset
    );
    station_manager_model u_station_manager_model (
        .mclk, .regBusy, .regAddr, .regWrEn, .regRdEn, .regWrData
    );
    task check(input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            error_cnt++;
            $display("FAIL %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check
    task close_out;
        check(16'(expQ.size()), 16'h0000);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    task rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] v);
        expQ.push_back({m, v});
        u_station_manager_model.access(1'b0, a, 16'h0000, 1'b0);
    endtask : rd
    task wr(input logic [15:0] d);
        u_station_manager_model.access(1'b1, CTRL_ADDR, d, 1'b0);
    endtask : wr
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Read answers are looked at mid-cycle, well away from the edge that launches them.
    always @(negedge mclk)
    begin
        cycles++;
        if (cycles > 3000)
        begin
            error_cnt++;
            close_out();
        end
        else if (regRdValid === 1'b1)
        begin
            note = expQ.size() > 0 ? expQ.pop_front() : 32'h1;
            check(regRdData & note[31:16], note[15:0]);
        end
    end
    initial
    begin
        void'($urandom(32'h9a75));
        rst = 1'b1;
        {configSourcePin, rateSelectPin, negFullDuplex, anRestartBegun} = 4'h8;
        {linkOkLive, macTxEn, lineRxDv, phyAddrPin, anStateLive, macTxData} = 15'h4000;
        lineRxData = 4'h0;
        negRate100 = 1'($urandom);
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        rd(CTRL_ADDR, 16'hffff, 16'h3400);
        check(16'(macOutOe_n), 16'h0001);
        macTxEn = 1'b1;
        @(negedge mclk);
        check(16'(lineTxEn), 16'h0000);
        macTxEn = 1'b0;
        rd(5'h05, 16'hffff, 16'h0000);
        u_station_manager_model.access(1'b1, CTRL_ADDR, 16'h017f, 1'b1);
        rd(CTRL_ADDR, 16'hffff, 16'h0100);
        check(16'({rate100, fullDuplex, autoNegEnable, macOutOe_n}), 16'h0004);
        wr(16'h2000);
        check(16'(rate100), 16'h0001);
        wr(16'h1000);
        check(16'(rate100), 16'(negRate100));
        macTxData = 4'($urandom);
        lineRxData = 4'($urandom);
        {macTxEn, lineRxDv} = 2'b11;
        @(negedge mclk);
        check(16'({lineTxEn, lineTxData}), 16'({1'b1, macTxData}));
        check(16'({macRxDv, macRxData}), 16'({1'b1, lineRxData}));
        {macTxEn, lineRxDv} = 2'b00;
        wr(16'h1200);
        rd(CTRL_ADDR, 16'h0200, 16'h0200);
        anRestartBegun = 1'b1;
        @(negedge mclk);
        anRestartBegun = 1'b0;
        rd(CTRL_ADDR, 16'h0200, 16'h0000);
        anStateLive = 3'h3;
        rd(DETAIL_STAT_ADDR, 16'h3801, 16'h1801);
        anStateLive = 3'h2;
        rd(DETAIL_STAT_ADDR, 16'h3801, 16'h1801);
        anStateLive = 3'h4;
        @(negedge mclk);
        anStateLive = 3'h2;
        rd(DETAIL_STAT_ADDR, 16'h3801, 16'h2001);
        rd(DETAIL_STAT_ADDR, 16'h3801, 16'h1001);
        repeat (2)
        begin
            linkOkLive = 1'b0;
            @(negedge mclk);
            linkOkLive = 1'b1;
            rd(DETAIL_STAT_ADDR, 16'h0001, 16'h0000);
        end
        rd(DETAIL_STAT_ADDR, 16'h0001, 16'h0001);
        linkOkLive = 1'b0;
        @(negedge mclk);
        linkOkLive = 1'b1;
        wr(16'h0800);
        rd(DETAIL_STAT_ADDR, 16'h0001, 16'h0001);
        rd(CTRL_ADDR, 16'hffff, 16'h0800);
        wr(16'h4000);
        macTxData = 4'($urandom);
        macTxEn = 1'b1;
        @(negedge mclk);
        check(16'({lineRxEnable, lineTxEn, collisionDetectEn}), 16'h0000);
        check(16'({macRxDv, macRxData}), 16'({1'b1, macTxData}));
        macTxEn = 1'b0;
        wr(16'h4080);
        check(16'(collisionDetectEn), 16'h0001);
        {configSourcePin, rateSelectPin} = 2'b01;
        repeat (4) @(negedge mclk);
        check(16'(rate100), 16'h0001);
        rd(DETAIL_STAT_ADDR, 16'h8000, 16'h8000);
        configSourcePin = 1'b1;
        wr(16'h8000);
        u_station_manager_model.access(1'b1, CTRL_ADDR, 16'h4000, 1'b1);
        u_station_manager_model.access(1'b0, CTRL_ADDR, 16'h0000, 1'b1);
        check(16'({regBusy, machineReset}), 16'h0003);
        rd(CTRL_ADDR, 16'hffff, 16'h3400);
        // A second hardware reset with a non-zero strap must leave the port connected.
        phyAddrPin = 5'($urandom) | 5'h01;
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        rd(CTRL_ADDR, 16'hffff, 16'h3000);
        check(16'(macOutOe_n), 16'h0000);
        repeat (3) @(negedge mclk);
        close_out();
    end
endmodule : tb_phy_mgmt_control_register
`default_nettype wire
